// [hdl/tcb_pkg.sv]
// Constants shared by the 16-bit timer core and its tick selector.
// Assumes an 8-bit register port and a single system clock domain.
package tcb_pkg;

    // Widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;
    localparam int FLAG_W = 3;
    localparam int PRE_W  = 10;

    // Register byte offsets
    localparam logic [3:0] ADDR_CNT_LO  = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI  = 4'h1;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h5;
    localparam logic [3:0] ADDR_CAP_LO  = 4'h6;
    localparam logic [3:0] ADDR_CAP_HI  = 4'h7;
    localparam logic [3:0] ADDR_CTRL_A  = 4'h8;
    localparam logic [3:0] ADDR_CTRL_B  = 4'h9;
    localparam logic [3:0] ADDR_FLAGS   = 4'hA;
    localparam logic [3:0] ADDR_MASK    = 4'hB;

    // Field positions
    localparam int CA_WGM_LSB = 0;
    localparam int CA_WGM_MSB = 1;
    localparam int CB_CS_LSB  = 0;
    localparam int CB_CS_MSB  = 2;
    localparam int CB_WGM_LSB = 3;
    localparam int CB_WGM_MSB = 4;
    localparam int FLAG_OVF   = 0;
    localparam int FLAG_CMPA  = 1;
    localparam int FLAG_CMPB  = 2;

    // Reset values
    localparam logic [7:0]  CTRL_A_RESET = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET = 8'h00;
    localparam logic [7:0]  HOLD_RESET   = 8'h00;
    localparam logic [2:0]  FLAGS_RESET  = 3'h0;
    localparam logic [2:0]  MASK_RESET   = 3'h0;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [7:0]  RD_UNMAPPED  = 8'h00;

    // Count limits
    localparam logic [15:0] CNT_FLOOR = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    // Clock select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler terminal masks
    localparam logic [9:0] PRE_MASK_8    = 10'h007;
    localparam logic [9:0] PRE_MASK_64   = 10'h03F;
    localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
    localparam logic [9:0] PRE_ONE       = 10'h001;

    // Waveform mode codes
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_PC8      = 4'h1;
    localparam logic [3:0] WGM_PC9      = 4'h2;
    localparam logic [3:0] WGM_PC10     = 4'h3;
    localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
    localparam logic [3:0] WGM_FAST8    = 4'h5;
    localparam logic [3:0] WGM_FAST9    = 4'h6;
    localparam logic [3:0] WGM_FAST10   = 4'h7;
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
    localparam logic [3:0] WGM_PC_CAP   = 4'hA;
    localparam logic [3:0] WGM_PC_CMPA  = 4'hB;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WGM_RESERVED = 4'hD;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
    localparam logic [3:0] WGM_FAST_CMPA = 4'hF;

    // Counting sequence shape
    typedef enum logic [1:0] {
        SLOPE_SINGLE,
        SLOPE_CTC,
        SLOPE_DUAL
    } tcb_slope_e;

endpackage : tcb_pkg

// [hdl/tcb_tick_sel.sv]
// Timer tick selector: prescaled system clock or synchronised external pin edge.
// Assumes the external pin is asynchronous to clk; the tick is a one-cycle pulse.
module tcb_tick_sel (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    input  wire logic [2:0] clockSelect,
    input  wire logic       extPin,
    output logic            tick
);

    logic       extSync1_q;
    logic       extSync2_q;
    logic       extPrev_q;
    logic [9:0] prescale_q;
    logic       tick_q;
    logic       tick_d;

    // Two-stage synchroniser, then one more stage for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            extSync1_q <= 1'b0;
            extSync2_q <= 1'b0;
            extPrev_q  <= 1'b0;
        end else if (clkEn) begin
            extSync1_q <= extPin;
            extSync2_q <= extSync1_q;
            extPrev_q  <= extSync2_q;
        end
    end

    // Free-running prescaler; it is shared by the divide-by-8 to divide-by-1024 ratios
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_q <= '0;
        end else if (clkEn) begin
            prescale_q <= prescale_q + tcb_pkg::PRE_ONE;
        end
    end

    // Source selection; stop code yields no tick at all
    always_comb begin
        tick_d = 1'b0;
        unique case (clockSelect)
            tcb_pkg::CS_STOP:     tick_d = 1'b0;
            tcb_pkg::CS_DIV1:     tick_d = 1'b1;
            tcb_pkg::CS_DIV8:     tick_d = &(prescale_q | ~tcb_pkg::PRE_MASK_8);
            tcb_pkg::CS_DIV64:    tick_d = &(prescale_q | ~tcb_pkg::PRE_MASK_64);
            tcb_pkg::CS_DIV256:   tick_d = &(prescale_q | ~tcb_pkg::PRE_MASK_256);
            tcb_pkg::CS_DIV1024:  tick_d = &(prescale_q | ~tcb_pkg::PRE_MASK_1024);
            tcb_pkg::CS_EXT_FALL: tick_d = extPrev_q & ~extSync2_q;
            tcb_pkg::CS_EXT_RISE: tick_d = ~extPrev_q & extSync2_q;
        endcase
    end

    // Registered so the counter sees a clean pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
        end else if (clkEn) begin
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : tcb_tick_sel

// [hdl/tcb_timer16.sv]
// 16-bit timer/counter core with byte-wise register access through a holding byte.
// Assumes a byte-wide register port, read data one cycle after the read strobe.
// Summary of operation
// - One shared upper-byte holding register per timer
// - Low-byte write loads holding byte plus data
// - Low-byte read copies upper byte into holding
// - Compare reads bypass the holding register entirely
// - Holding byte survives several low-byte writes
// - Three-bit clock select; zero stops counter
// - Count upper location maps to holding register
// - Counter is sixteen-bit, counts up or down
// - Step, direction, clear controls; top, floor indications
// - Count visible as two byte locations
// - Each tick clears, increments or decrements count
// - Count accessible with or without ticks
// - CPU count write beats clear or step
// - Four-bit mode split across control B, A
// - Overflow flag set per mode, raises interrupt
// - Floor is zero, maximum is all ones
//
// The address map and the strobed register port were left to the implementer.
module tcb_timer16 (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    input  wire logic        extTickPin,
    output logic             irq,
    output logic      [15:0] timerCount
);

    logic [15:0]       count_q;
    logic [15:0]       count_d;
    logic              countDown_q;
    logic              countDown_d;
    logic [7:0]        holdByte_q;
    logic [15:0]       cmpA_q;
    logic [15:0]       cmpB_q;
    logic [15:0]       capture_q;
    logic [7:0]        ctrlA_q;
    logic [7:0]        ctrlB_q;
    logic [2:0]        flags_q;
    logic [2:0]        mask_q;
    logic [7:0]        regRdData_q;
    logic              irq_q;
    logic              tick;
    logic [3:0]        waveMode;
    logic [2:0]        clockSelect;
    logic [15:0]       topValue;
    tcb_pkg::tcb_slope_e slope;
    logic              countStep;
    logic              countClear;
    logic              atTop;
    logic              atFloor;
    logic              countWrite;
    logic              holdWrite;
    logic              holdLoad;
    logic [2:0]        events;
    logic [2:0]        flagClear;

    // Control fields: mode bits split over both control registers
    assign waveMode    = {ctrlB_q[tcb_pkg::CB_WGM_MSB:tcb_pkg::CB_WGM_LSB],
                          ctrlA_q[tcb_pkg::CA_WGM_MSB:tcb_pkg::CA_WGM_LSB]};
    assign clockSelect = ctrlB_q[tcb_pkg::CB_CS_MSB:tcb_pkg::CB_CS_LSB];

    // Tick source; the stop code produces no tick
    tcb_tick_sel u_tick_sel (
        .clk         (clk),
        .reset_n     (reset_n),
        .clkEn       (clkEn),
        .clockSelect (clockSelect),
        .extPin      (extTickPin),
        .tick        (tick)
    );

    // Mode decode: top value and sequence shape
    always_comb begin
        topValue = tcb_pkg::CNT_MAX;
        slope    = tcb_pkg::SLOPE_SINGLE;
        unique case (waveMode)
            tcb_pkg::WGM_NORMAL:    begin topValue = tcb_pkg::CNT_MAX;   slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_PC8:       begin topValue = tcb_pkg::TOP_8BIT;  slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_PC9:       begin topValue = tcb_pkg::TOP_9BIT;  slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_PC10:      begin topValue = tcb_pkg::TOP_10BIT; slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_CTC_CMPA:  begin topValue = cmpA_q;             slope = tcb_pkg::SLOPE_CTC;    end
            tcb_pkg::WGM_FAST8:     begin topValue = tcb_pkg::TOP_8BIT;  slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_FAST9:     begin topValue = tcb_pkg::TOP_9BIT;  slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_FAST10:    begin topValue = tcb_pkg::TOP_10BIT; slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_PFC_CAP:   begin topValue = capture_q;          slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_PFC_CMPA:  begin topValue = cmpA_q;             slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_PC_CAP:    begin topValue = capture_q;          slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_PC_CMPA:   begin topValue = cmpA_q;             slope = tcb_pkg::SLOPE_DUAL;   end
            tcb_pkg::WGM_CTC_CAP:   begin topValue = capture_q;          slope = tcb_pkg::SLOPE_CTC;    end
            tcb_pkg::WGM_RESERVED:  begin topValue = tcb_pkg::CNT_MAX;   slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_FAST_CAP:  begin topValue = capture_q;          slope = tcb_pkg::SLOPE_SINGLE; end
            tcb_pkg::WGM_FAST_CMPA: begin topValue = cmpA_q;             slope = tcb_pkg::SLOPE_SINGLE; end
        endcase
    end

    // Bus decode for the holding path
    assign countWrite = regWrite && (regAddr == tcb_pkg::ADDR_CNT_LO);
    assign holdWrite  = regWrite && (regAddr == tcb_pkg::ADDR_CNT_HI  ||
                                     regAddr == tcb_pkg::ADDR_CMPA_HI ||
                                     regAddr == tcb_pkg::ADDR_CMPB_HI ||
                                     regAddr == tcb_pkg::ADDR_CAP_HI);
    // Compare low reads are deliberately absent here
    assign holdLoad   = regRead && (regAddr == tcb_pkg::ADDR_CNT_LO ||
                                    regAddr == tcb_pkg::ADDR_CAP_LO);

    // Counter unit control and indications
    assign atTop     = (count_q == topValue);
    assign atFloor   = (count_q == tcb_pkg::CNT_FLOOR);
    assign countStep = tick;
    assign countClear = countStep && (slope != tcb_pkg::SLOPE_DUAL) && atTop;

    // Next count; dual slope turns round at top and at floor
    always_comb begin
        countDown_d = countDown_q;
        count_d     = count_q;
        if (slope == tcb_pkg::SLOPE_DUAL) begin
            if (!countDown_q && atTop) begin
                countDown_d = 1'b1;
            end else if (countDown_q && atFloor) begin
                countDown_d = 1'b0;
            end
        end else begin
            countDown_d = 1'b0;
        end
        if (countClear) begin
            count_d = tcb_pkg::CNT_FLOOR;
        end else if (countDown_d) begin
            count_d = count_q - tcb_pkg::CNT_ONE;
        end else begin
            count_d = count_q + tcb_pkg::CNT_ONE;
        end
    end

    // Count register: a CPU write wins over any step or clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q     <= tcb_pkg::CNT_RESET;
            countDown_q <= 1'b0;
        end else if (clkEn) begin
            if (countWrite) begin
                count_q <= {holdByte_q, regWrData};
            end else if (countStep) begin
                count_q     <= count_d;
                countDown_q <= countDown_d;
            end
        end
    end

    // Holding byte: written by any upper write, loaded by holding-path low reads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdByte_q <= tcb_pkg::HOLD_RESET;
        end else if (clkEn) begin
            if (holdWrite) begin
                holdByte_q <= regWrData;
            end else if (holdLoad) begin
                holdByte_q <= (regAddr == tcb_pkg::ADDR_CNT_LO) ? count_q[15:8]
                                                                 : capture_q[15:8];
            end
        end
    end

    // Compare and capture words; low-byte writes commit the whole word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmpA_q    <= tcb_pkg::CNT_RESET;
            cmpB_q    <= tcb_pkg::CNT_RESET;
            capture_q <= tcb_pkg::CNT_RESET;
        end else if (clkEn && regWrite) begin
            if (regAddr == tcb_pkg::ADDR_CMPA_LO) cmpA_q    <= {holdByte_q, regWrData};
            if (regAddr == tcb_pkg::ADDR_CMPB_LO) cmpB_q    <= {holdByte_q, regWrData};
            if (regAddr == tcb_pkg::ADDR_CAP_LO)  capture_q <= {holdByte_q, regWrData};
        end
    end

    // Plain byte registers have no access restrictions
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlA_q <= tcb_pkg::CTRL_A_RESET;
            ctrlB_q <= tcb_pkg::CTRL_B_RESET;
            mask_q  <= tcb_pkg::MASK_RESET;
        end else if (clkEn && regWrite) begin
            if (regAddr == tcb_pkg::ADDR_CTRL_A) ctrlA_q <= regWrData;
            if (regAddr == tcb_pkg::ADDR_CTRL_B) ctrlB_q <= regWrData;
            if (regAddr == tcb_pkg::ADDR_MASK)   mask_q  <= regWrData[2:0];
        end
    end

    // Events: overflow point depends on the sequence shape
    always_comb begin
        events = '0;
        unique case (slope)
            tcb_pkg::SLOPE_SINGLE: events[tcb_pkg::FLAG_OVF] = countStep && atTop;
            tcb_pkg::SLOPE_CTC:    events[tcb_pkg::FLAG_OVF] = countStep &&
                                                               (count_q == tcb_pkg::CNT_MAX);
            tcb_pkg::SLOPE_DUAL:   events[tcb_pkg::FLAG_OVF] = countStep && atFloor;
        endcase
        events[tcb_pkg::FLAG_CMPA] = countStep && (count_q == cmpA_q);
        events[tcb_pkg::FLAG_CMPB] = countStep && (count_q == cmpB_q);
    end

    // A read of the flag register clears it; a same-cycle event still lands
    assign flagClear = (regRead && regAddr == tcb_pkg::ADDR_FLAGS) ? 3'h7 : 3'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= tcb_pkg::FLAGS_RESET;
        end else if (clkEn) begin
            flags_q <= (flags_q & ~flagClear) | events;
        end
    end

    // Level interrupt, one cycle behind the flags to keep the output registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else if (clkEn) begin
            irq_q <= |(flags_q & mask_q);
        end
    end

    // Read data, valid the cycle after the strobe; upper count byte is the holding byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData_q <= tcb_pkg::RD_UNMAPPED;
        end else if (clkEn) begin
            if (regRead) begin
                case (regAddr)
                    tcb_pkg::ADDR_CNT_LO:  regRdData_q <= count_q[7:0];
                    tcb_pkg::ADDR_CNT_HI:  regRdData_q <= holdByte_q;
                    tcb_pkg::ADDR_CMPA_LO: regRdData_q <= cmpA_q[7:0];
                    tcb_pkg::ADDR_CMPA_HI: regRdData_q <= cmpA_q[15:8];
                    tcb_pkg::ADDR_CMPB_LO: regRdData_q <= cmpB_q[7:0];
                    tcb_pkg::ADDR_CMPB_HI: regRdData_q <= cmpB_q[15:8];
                    tcb_pkg::ADDR_CAP_LO:  regRdData_q <= capture_q[7:0];
                    tcb_pkg::ADDR_CAP_HI:  regRdData_q <= holdByte_q;
                    tcb_pkg::ADDR_CTRL_A:  regRdData_q <= ctrlA_q;
                    tcb_pkg::ADDR_CTRL_B:  regRdData_q <= ctrlB_q;
                    tcb_pkg::ADDR_FLAGS:   regRdData_q <= {5'h00, flags_q};
                    tcb_pkg::ADDR_MASK:    regRdData_q <= {5'h00, mask_q};
                    default:               regRdData_q <= tcb_pkg::RD_UNMAPPED;
                endcase
            end else begin
                regRdData_q <= tcb_pkg::RD_UNMAPPED;
            end
        end
    end

    assign regRdData  = regRdData_q;
    assign irq        = irq_q;
    assign timerCount = count_q;

    // Checks on the byte access path and the counter

    sequence s_upper_write;
        clkEn && regWrite && regAddr == tcb_pkg::ADDR_CNT_HI;
    endsequence

    sequence s_lower_write;
        clkEn && regWrite && regAddr == tcb_pkg::ADDR_CNT_LO;
    endsequence

    // Pairs as a byte master issues them, one idle cycle apart
    // The gap must leave the holding byte alone for the pair to be atomic
    sequence s_read_pair;
        clkEn && regRead && regAddr == tcb_pkg::ADDR_CNT_LO ##1
        !(clkEn && (holdWrite || holdLoad)) ##1
        clkEn && regRead && regAddr == tcb_pkg::ADDR_CNT_HI;
    endsequence

    sequence s_cmp_pair;
        clkEn && regWrite && regAddr == tcb_pkg::ADDR_CMPA_LO ##1
        !(clkEn && (holdWrite || holdLoad)) ##1
        clkEn && regWrite && regAddr == tcb_pkg::ADDR_CMPB_LO;
    endsequence

    a_word_write_pair: assert property (@(posedge clk) disable iff (!reset_n)
        s_lower_write |=> count_q == {$past(holdByte_q), $past(regWrData)})
        else $error("count word not assembled from holding byte and lower write");

    a_upper_to_hold: assert property (@(posedge clk) disable iff (!reset_n)
        s_upper_write |=> holdByte_q == $past(regWrData))
        else $error("upper count write missed the holding byte");

    a_low_read_copy: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && regRead && regAddr == tcb_pkg::ADDR_CNT_LO |=>
            holdByte_q == $past(count_q[15:8]))
        else $error("low count read did not copy upper byte");

    a_word_read_pair: assert property (@(posedge clk) disable iff (!reset_n)
        s_read_pair |=> regRdData_q == $past(count_q[15:8], 3))
        else $error("upper count read did not return the snapshot");

    a_cmp_read_direct: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && regRead &&
        (regAddr == tcb_pkg::ADDR_CMPA_HI || regAddr == tcb_pkg::ADDR_CMPB_HI) |=>
            holdByte_q == $past(holdByte_q) && regRdData_q == ($past(regAddr) ==
            tcb_pkg::ADDR_CMPA_HI ? $past(cmpA_q[15:8]) : $past(cmpB_q[15:8])))
        else $error("compare read used or disturbed the holding byte");

    a_hold_retain: assert property (@(posedge clk) disable iff (!reset_n)
        !(clkEn && (holdWrite || holdLoad)) |=> holdByte_q == $past(holdByte_q))
        else $error("holding byte changed without an access");

    a_shared_upper: assert property (@(posedge clk) disable iff (!reset_n)
        s_cmp_pair |=> cmpB_q[15:8] == cmpA_q[15:8])
        else $error("upper byte not reused across low writes");

    a_stop_freeze: assert property (@(posedge clk) disable iff (!reset_n)
        clockSelect == tcb_pkg::CS_STOP && $past(clockSelect) == tcb_pkg::CS_STOP &&
        !countWrite |=> count_q == $past(count_q))
        else $error("counter moved while stopped");

    a_ctc_clear: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && tick && !countWrite && waveMode == tcb_pkg::WGM_CTC_CMPA &&
        count_q == cmpA_q |=> count_q == tcb_pkg::CNT_FLOOR)
        else $error("counter not cleared at compare top");

    a_overflow_set: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && tick && !countWrite && waveMode == tcb_pkg::WGM_NORMAL &&
        count_q == tcb_pkg::CNT_MAX |=>
            count_q == tcb_pkg::CNT_FLOOR && flags_q[tcb_pkg::FLAG_OVF])
        else $error("overflow not flagged at wrap");

    a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && |(flags_q & mask_q) |=> irq_q)
        else $error("interrupt missing for unmasked flag");

    a_irq_clear: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && !(|(flags_q & mask_q)) |=> !irq_q)
        else $error("interrupt held without an unmasked flag");

    // Plain up count below all ones; the wrap is checked separately
    a_count_step: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && tick && !countWrite && waveMode == tcb_pkg::WGM_NORMAL &&
        count_q != tcb_pkg::CNT_MAX |=> count_q == $past(count_q) + tcb_pkg::CNT_ONE)
        else $error("count did not step up by one");

endmodule : tcb_timer16

// [verif/tcb_cpu_model.sv]
// CPU model: byte-wide register port master for the timer core.
// Assumes one clock; one strobe cycle per access, read data the cycle after.
module tcb_cpu_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    output logic      [3:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrite,
    output logic            regRead
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // Accesses never interleave, as if interrupts were masked
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regWrData <= ~d; // Released data shows no stale value
    endtask : wr
    // Read data is looked at mid-cycle, where it has settled
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(negedge clk);
        q = regRdData;
    endtask : rd
endmodule : tcb_cpu_model

// [verif/tcb_timer16_bench.sv]
// Bench for the timer core: byte access, holding byte, ticks, interrupt.
// Assumes the CPU model drives the register port; clock enable high, pin idle.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tcb_timer16_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, clkEn, extTickPin, regWrite, regRead, irq;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, regRdData, d;
    logic [15:0] timerCount, w;
    int          failures, n_checks;
    tcb_cpu_model u_cpu (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    tcb_timer16 u_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .extTickPin(extTickPin), .irq(irq), .timerCount(timerCount));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Upper byte first on writes, lower first on reads
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        u_cpu.wr(a + 4'h1, v[15:8]);
        u_cpu.wr(a, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        u_cpu.rd(a, v[7:0]);
        u_cpu.rd(a + 4'h1, v[15:8]);
    endtask : rd16
    task automatic t_count();
        `CHK(irq, 1'b0)
        u_cpu.rd(4'h1, d);
        `CHK(d, 8'h00)
        wr16(4'h0, 16'h01FF);
        @(negedge clk);
        `CHK(timerCount, 16'h01FF)
        repeat (8) @(posedge clk);
        rd16(4'h0, w);
        `CHK(w, 16'h01FF)
        $display("count access done");
    endtask : t_count
    // One upper write serves two compares; compare reads bypass the holding byte
    task automatic t_hold();
        wr16(4'h2, 16'hAB34);
        u_cpu.wr(4'h4, 8'h56);
        u_cpu.wr(4'h7, 8'hC3);
        rd16(4'h4, w);
        `CHK(w, 16'hAB56)
        u_cpu.rd(4'h1, d);
        `CHK(d, 8'hC3)
        u_cpu.wr(4'h6, 8'h78);
        rd16(4'h6, w);
        `CHK(w, 16'hC378)
        u_cpu.rd(4'hC, d);
        `CHK(d, 8'h00)
        $display("holding byte done");
    endtask : t_hold
    // Mode 5 needs bits from both control registers; wraps past 00FF
    task automatic t_ovf();
        wr16(4'h0, 16'h00FE);
        u_cpu.wr(4'hB, 8'h01);
        u_cpu.wr(4'h8, 8'h01);
        u_cpu.wr(4'h9, 8'h09);
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
        u_cpu.wr(4'h9, 8'h08);
        @(negedge clk);
        `CHK(irq, 1'b1)
        `CHK(timerCount[15:8], 8'h00)
        u_cpu.rd(4'hA, d);
        `CHK(d[0], 1'b1)
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        $display("overflow done");
    endtask : t_ovf
    // A write during a tick wins, then counting resumes from it
    task automatic t_prio();
        u_cpu.wr(4'h8, 8'h00);
        u_cpu.wr(4'h9, 8'h01);
        wr16(4'h0, 16'h0010);
        @(negedge clk);
        `CHK(timerCount, 16'h0010)
        @(negedge clk);
        `CHK(timerCount, 16'h0011)
        u_cpu.wr(4'h9, 8'h00);
        $display("write priority done");
    endtask : t_prio
    // Compare top clears the count; only the compare flag rises
    task automatic t_ctc();
        wr16(4'h2, 16'h0005);
        wr16(4'h0, 16'h0000);
        u_cpu.wr(4'h9, 8'h09);
        repeat (20) @(posedge clk);
        u_cpu.wr(4'h9, 8'h08);
        @(negedge clk);
        `CHK(timerCount < 16'h0006, 1'b1)
        `CHK(irq, 1'b0)
        u_cpu.rd(4'hA, d);
        `CHK(d, 8'h02)
        $display("compare top done");
    endtask : t_ctc
    // Rising pin edge steps the count; all ones wraps, falling edge does nothing
    task automatic t_ext();
        wr16(4'h0, 16'hFFFF);
        u_cpu.wr(4'h9, 8'h07);
        @(posedge clk);
        extTickPin <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(timerCount, 16'h0000)
        `CHK(irq, 1'b1)
        extTickPin <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(timerCount, 16'h0000)
        u_cpu.wr(4'h9, 8'h00);
        $display("external tick done");
    endtask : t_ext
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Watchdog well beyond the 150 or so cycles the tests take
    initial begin
        #20000;
        failures++;
        stop_test();
    end
    // Main sequence
    initial begin
        failures = 0;
        n_checks = 0;
        clkEn = 1'b1;
        extTickPin = 1'b0;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_count();
        t_hold();
        t_ovf();
        t_prio();
        t_ctc();
        t_ext();
        stop_test();
    end
endmodule : tcb_timer16_bench
